// ===== pkg/adc_map.svh
// register map, field positions and timing counts of the converter control
`ifndef ADC_MAP_SVH
`define ADC_MAP_SVH

`define OFS_STATUS_CONTROL 8'h15
`define OFS_RESULT         8'h17
`define OFS_IRQ_STATUS     8'h18
`define OFS_IRQ_MASK       8'h19

`define BIT_DONE           7
`define BIT_RC             6
`define BIT_ON             5
`define CH_HI              3
`define CH_LO              0
`define IRQ_BIT_DONE       0

`define STATUS_RESET       8'h00
`define BYTE_ZERO          8'h00
`define BYTE_FULL          8'hFF
`define SAR_FIRST          8'h80
`define SAR_MSB_IDX        3'h7
`define SAR_LSB_IDX        3'h0
`define CH_RESET           4'h0

`define CH_EXT0            4'h0
`define CH_EXT1            4'h1
`define CH_HIGH            4'h8
`define CH_MID             4'h9
`define CH_LOW_FIRST       4'hA

`define SAMPLE_CYCLES      4'hC
`define SETTLE_TICKS       4'h4
`define CNT_ZERO           4'h0
`define CNT_ONE            4'h1

`endif

// ===== pkg/adc_pkg.sv
// types shared by the converter control, its checker and its bench
package adc_pkg;

   typedef enum logic [2:0] {
      src_none  = 3'b000,
      src_ext0  = 3'b001,
      src_ext1  = 3'b010,
      src_high  = 3'b011,
      src_mid   = 3'b100,
      src_low   = 3'b101
   } source_t;

   typedef enum logic [1:0] {
      st_off    = 2'b00,
      st_sample = 2'b01,
      st_trial  = 2'b10
   } conv_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;

   typedef struct packed {
      source_t    source;
      logic       sample_switch;
      logic [7:0] dac_code;
      logic       rc_osc_enable;
      logic       converter_power_on;
   } analog_drive_t;

endpackage : adc_pkg

// ===== src/pin_sampler.sv
// three-stage sampler for asynchronous inputs of the converter
`timescale 1ns/1ps
`default_nettype none

module pin_sampler (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [1:0] pin_in,
   output var  logic [1:0] stable
);

   logic [1:0] meta_r;
   logic [1:0] s2_r;
   logic [1:0] s3_r;
   logic [1:0] held_r;
   logic [1:0] held_nxt;

   // a change counts only once stages two and three agree
   always_comb begin
      held_nxt = held_r;
      for (int i = 0; i < 2; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            held_nxt[i] = s3_r[i];
         end
      end
   end

   // agreed value passed on at once: a fourth stage would miss the settle window
   assign stable = held_nxt;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= 2'h0;
         s2_r   <= 2'h0;
         s3_r   <= 2'h0;
         held_r <= 2'h0;
      end else begin
         meta_r <= pin_in;
         s2_r   <= meta_r;
         s3_r   <= s2_r;
         held_r <= held_nxt;
      end
   end

endmodule : pin_sampler

`default_nettype wire

// ===== src/sar_adc_control.sv
// control logic of an 8-bit successive-approximation converter with register port
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.svh"

module sar_adc_control
   import adc_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire adc_pkg::bus_req_t      bus_req,
   output var  logic [7:0]             rdata,
   output var  logic                   irq,
   input  wire logic                   cmp_above,
   input  wire logic                   rc_clk_pin,
   output var  adc_pkg::analog_drive_t analog
);

   // channel code to multiplexer source; reserved codes connect nothing
   function automatic source_t chan_source(input logic [3:0] ch);
      source_t s;
      s = src_none;
      if (ch == `CH_EXT0) begin
         s = src_ext0;
      end else if (ch == `CH_EXT1) begin
         s = src_ext1;
      end else if (ch == `CH_HIGH) begin
         s = src_high;
      end else if (ch == `CH_MID) begin
         s = src_mid;
      end else if (ch >= `CH_LOW_FIRST) begin
         s = src_low;
      end
      return s;
   endfunction : chan_source

   // one-hot weight of the bit under trial
   function automatic logic [7:0] trial_bit(input logic [2:0] idx);
      return 8'(8'h01 << idx);
   endfunction : trial_bit

   logic [1:0]  stable;
   logic        cmp_stable;
   logic        rc_stable;

   logic        rc_r;
   logic        rc_nxt;
   logic        on_r;
   logic        on_nxt;
   logic [3:0]  chan_r;
   logic [3:0]  chan_nxt;
   logic        done_r;
   logic        done_nxt;
   logic [7:0]  result_r;
   logic [7:0]  result_nxt;
   logic        irq_stat_r;
   logic        irq_stat_nxt;
   logic        irq_mask_r;
   logic        irq_mask_nxt;
   logic [7:0]  rdata_nxt;

   conv_state_t state_r;
   conv_state_t state_nxt;
   logic [7:0]  sar_r;
   logic [7:0]  sar_nxt;
   logic [2:0]  bit_r;
   logic [2:0]  bit_nxt;
   logic [3:0]  cnt_r;
   logic [3:0]  cnt_nxt;
   logic        rc_prev_r;
   logic        rc_prev_nxt;

   logic        wr_status;
   logic        rd_result;
   logic        conv_tick;
   logic        complete;
   logic [7:0]  decided;

   pin_sampler u_pin_sampler (
      .clk     (clk),
      .reset_n (reset_n),
      .pin_in  ({rc_clk_pin, cmp_above}),
      .stable  (stable)
   );

   assign cmp_stable = stable[0];
   assign rc_stable  = stable[1];

   assign wr_status = bus_req.wr && (bus_req.addr == `OFS_STATUS_CONTROL);
   assign rd_result = bus_req.rd && (bus_req.addr == `OFS_RESULT);

   // converter clock: every bus clock, or each rising RC edge
   assign conv_tick = rc_r ? (rc_stable && !rc_prev_r) : 1'b1;

   // comparator high keeps the trial bit; full scale keeps all
   assign decided = cmp_stable ? sar_r : (sar_r & ~trial_bit(bit_r));

   assign complete = (state_r == st_trial) && conv_tick && !wr_status
                     && (cnt_r == `SETTLE_TICKS - `CNT_ONE) && (bit_r == `SAR_LSB_IDX);

   // conversion sequencer
   always_comb begin
      state_nxt   = state_r;
      sar_nxt     = sar_r;
      bit_nxt     = bit_r;
      cnt_nxt     = cnt_r;
      rc_prev_nxt = rc_stable;
      result_nxt  = result_r;
      if (wr_status) begin
         // abort; restart on the newly selected channel only when ON is written as one
         cnt_nxt = `CNT_ZERO;
         sar_nxt = `BYTE_ZERO;
         bit_nxt = `SAR_MSB_IDX;
         if (bus_req.wdata[`BIT_ON]) begin
            state_nxt = st_sample;
         end else begin
            state_nxt = st_off;
         end
      end else begin
         case (state_r)
            st_off: begin
               cnt_nxt = `CNT_ZERO;
               if (on_r) begin
                  state_nxt = st_sample;
               end
            end
            st_sample: begin
               // sample window counts bus clocks whatever the clock source
               if (cnt_r == `SAMPLE_CYCLES - `CNT_ONE) begin
                  state_nxt = st_trial;
                  cnt_nxt   = `CNT_ZERO;
                  bit_nxt   = `SAR_MSB_IDX;
                  sar_nxt   = `SAR_FIRST;
               end else begin
                  cnt_nxt = cnt_r + `CNT_ONE;
               end
            end
            st_trial: begin
               // each step waits for the comparator to pass the sampler
               if (conv_tick) begin
                  if (cnt_r == `SETTLE_TICKS - `CNT_ONE) begin
                     cnt_nxt = `CNT_ZERO;
                     if (bit_r == `SAR_LSB_IDX) begin
                        result_nxt = decided;
                        sar_nxt    = `BYTE_ZERO;
                        state_nxt  = st_sample;
                     end else begin
                        sar_nxt = decided | trial_bit(bit_r - 3'h1);
                        bit_nxt = bit_r - 3'h1;
                     end
                  end else begin
                     cnt_nxt = cnt_r + `CNT_ONE;
                  end
               end
            end
            default: begin
               state_nxt = st_off;
               cnt_nxt   = `CNT_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r   <= st_off;
         sar_r     <= `BYTE_ZERO;
         bit_r     <= `SAR_MSB_IDX;
         cnt_r     <= `CNT_ZERO;
         rc_prev_r <= 1'b0;
         result_r  <= `BYTE_ZERO;
      end else begin
         state_r   <= state_nxt;
         sar_r     <= sar_nxt;
         bit_r     <= bit_nxt;
         cnt_r     <= cnt_nxt;
         rc_prev_r <= rc_prev_nxt;
         result_r  <= result_nxt;
      end
   end

   // register file and flags
   always_comb begin
      rc_nxt       = rc_r;
      on_nxt       = on_r;
      chan_nxt     = chan_r;
      done_nxt     = done_r;
      irq_stat_nxt = irq_stat_r;
      irq_mask_nxt = irq_mask_r;
      rdata_nxt    = `BYTE_ZERO;
      if (wr_status) begin
         rc_nxt   = bus_req.wdata[`BIT_RC];
         on_nxt   = bus_req.wdata[`BIT_ON];
         chan_nxt = bus_req.wdata[`CH_HI:`CH_LO];
         done_nxt = 1'b0;
      end
      if (rd_result) begin
         done_nxt = 1'b0;
      end
      if (bus_req.wr && (bus_req.addr == `OFS_IRQ_MASK)) begin
         irq_mask_nxt = bus_req.wdata[`IRQ_BIT_DONE];
      end
      if (bus_req.wr && (bus_req.addr == `OFS_IRQ_STATUS)
          && bus_req.wdata[`IRQ_BIT_DONE]) begin
         irq_stat_nxt = 1'b0;
      end
      // a completion beats a clear in the same cycle
      if (complete) begin
         done_nxt     = 1'b1;
         irq_stat_nxt = 1'b1;
      end
      if (bus_req.rd) begin
         case (bus_req.addr)
            `OFS_STATUS_CONTROL: begin
               rdata_nxt[`BIT_DONE]      = done_r;
               rdata_nxt[`BIT_RC]        = rc_r;
               rdata_nxt[`BIT_ON]        = on_r;
               rdata_nxt[`CH_HI:`CH_LO]  = chan_r;
            end
            `OFS_RESULT: begin
               rdata_nxt = result_r;
            end
            `OFS_IRQ_STATUS: begin
               rdata_nxt[`IRQ_BIT_DONE] = irq_stat_r;
            end
            `OFS_IRQ_MASK: begin
               rdata_nxt[`IRQ_BIT_DONE] = irq_mask_r;
            end
            default: begin
               rdata_nxt = `BYTE_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rc_r       <= 1'b0;
         on_r       <= 1'b0;
         chan_r     <= `CH_RESET;
         done_r     <= 1'b0;
         irq_stat_r <= 1'b0;
         irq_mask_r <= 1'b0;
         rdata      <= `BYTE_ZERO;
      end else begin
         rc_r       <= rc_nxt;
         on_r       <= on_nxt;
         chan_r     <= chan_nxt;
         done_r     <= done_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         rdata      <= rdata_nxt;
      end
   end

   assign irq = irq_stat_r && irq_mask_r;

   // analog front end: mux, sample switch, trial code, power
   always_comb begin
      analog.source             = chan_source(chan_r);
      analog.sample_switch      = (state_r == st_sample);
      analog.dac_code           = sar_r;
      // oscillator may run alone so it can settle before use
      analog.rc_osc_enable      = rc_r;
      analog.converter_power_on = on_r;
   end

endmodule : sar_adc_control

`default_nettype wire

// ===== bench/sar_adc_checker.sv
// port-level assertions of the converter control
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.svh"

module sar_adc_checker
   import adc_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   reset_n,
   input wire adc_pkg::bus_req_t      bus_req,
   input wire logic [7:0]             rdata,
   input wire logic                   irq,
   input wire logic                   cmp_above,
   input wire logic                   rc_clk_pin,
   input wire adc_pkg::analog_drive_t analog
);
   logic       wr_sc;
   logic       rd_sc;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   assign wr_sc = bus_req.wr && bus_req.addr == `OFS_STATUS_CONTROL;
   assign rd_sc = bus_req.rd && bus_req.addr == `OFS_STATUS_CONTROL;

   // a status write restarts the sampling count
   always_comb begin
      cnt_nxt = `CNT_ZERO;
      if (!wr_sc && analog.sample_switch) cnt_nxt = cnt_r + `CNT_ONE;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) cnt_r <= `CNT_ZERO;
      else cnt_r <= cnt_nxt;
   end

   function automatic source_t src_of(input logic [3:0] c);
      if (c == `CH_EXT0) return src_ext0;
      if (c == `CH_EXT1) return src_ext1;
      if (c == `CH_HIGH) return src_high;
      if (c == `CH_MID) return src_mid;
      if (c >= `CH_LOW_FIRST) return src_low;
      return src_none;
   endfunction : src_of

   rdata_idle_a: assert property (!bus_req.rd |=> rdata == `BYTE_ZERO)
      else $error("read data not zero outside a read");
   ctl_bits_a: assert property (wr_sc |=> analog.converter_power_on == $past(bus_req.wdata[`BIT_ON])
      && analog.rc_osc_enable == $past(bus_req.wdata[`BIT_RC])) else $error("power bits differ from write");
   mux_sel_a: assert property (wr_sc |=> analog.source == src_of($past(bus_req.wdata[`CH_HI:`CH_LO])))
      else $error("mux source differs from channel");
   restart_a: assert property (wr_sc && bus_req.wdata[`BIT_ON] |=> analog.sample_switch
      && analog.dac_code == `BYTE_ZERO) else $error("write did not restart sampling");
   off_idle_a: assert property (!analog.converter_power_on |-> !analog.sample_switch)
      else $error("sampling while converter off");
   sample_len_a: assert property (analog.sample_switch |-> cnt_r < `SAMPLE_CYCLES)
      else $error("sampling phase too long");
   sample_end_a: assert property ($fell(analog.sample_switch) && !$past(wr_sc)
      |-> cnt_r == `SAMPLE_CYCLES && analog.dac_code == `SAR_FIRST) else $error("bad end of sampling");
   done_clear_a: assert property (wr_sc ##[1:2] rd_sc |=> !rdata[`BIT_DONE])
      else $error("done flag survived status write");
   irq_mask_a: assert property (bus_req.wr && bus_req.addr == `OFS_IRQ_MASK && !bus_req.wdata[0] |=> !irq)
      else $error("interrupt not masked");
endmodule : sar_adc_checker

bind sar_adc_control sar_adc_checker sar_adc_checker_i (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
   .rdata(rdata), .irq(irq), .cmp_above(cmp_above), .rc_clk_pin(rc_clk_pin), .analog(analog));

`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench of the converter control
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.svh"

module testbench;
   import adc_pkg::*;
   typedef struct packed {
      logic [3:0] ch;
      logic [7:0] v0;
      logic [7:0] v1;
      logic [7:0] res;
   } row_t;
   logic          clk;
   logic          reset_n;
   bus_req_t      bus_req;
   logic [7:0]    rdata;
   logic          irq;
   logic          cmp_above;
   logic          rc_clk_pin;
   logic          rc_div;
   analog_drive_t analog;
   logic [7:0]    v0;
   logic [7:0]    v1;
   logic [7:0]    level;
   logic [7:0]    rv;
   int            err_count;
   int            checked;
   int            n;
   row_t          rows [8];

   sar_adc_control sar_adc_control_i (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
      .irq(irq), .cmp_above(cmp_above), .rc_clk_pin(rc_clk_pin), .analog(analog));

   always #4 clk = ~clk;
   // free-running oscillator at a quarter of the bus clock; each level lasts the two bus clocks the pin filter needs
   always @(posedge clk) begin
      rc_div <= ~rc_div;
      if (rc_div) begin
         rc_clk_pin <= ~rc_clk_pin;
      end
   end

   // ideal comparator; midpoint taken as half scale
   always_comb begin
      case (analog.source)
         src_ext0: level = v0;
         src_ext1: level = v1;
         src_high: level = `BYTE_FULL;
         src_mid:  level = `SAR_FIRST;
         default:  level = `BYTE_ZERO;
      endcase
   end
   assign cmp_above = level >= analog.dac_code;

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req.wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: `BYTE_ZERO, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1 check(what, rdata, exp);
   endtask : rdc

   task automatic wait_irq(input int lim);
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1 n++;
      end
      if (irq !== 1'b1) begin
         check("irq wait", {7'h00, irq}, 8'h01);
         stop_test();
      end
   endtask : wait_irq

   // stop, clear the sticky bit, then start so the count begins clean
   task automatic convert(input logic [7:0] ctl, input logic [7:0] exp, input int lim);
      wr(`OFS_STATUS_CONTROL, `BYTE_ZERO);
      wr(`OFS_IRQ_STATUS, 8'h01);
      wr(`OFS_STATUS_CONTROL, ctl);
      rdc("status after write", `OFS_STATUS_CONTROL, ctl & 8'h6F);
      wait_irq(lim);
      rdc("status done", `OFS_STATUS_CONTROL, (ctl & 8'h6F) | 8'h80);
      rdc("result", `OFS_RESULT, exp);
      rdc("status after result", `OFS_STATUS_CONTROL, ctl & 8'h6F);
   endtask : convert

   task automatic do_reset();
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
   endtask : do_reset

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      rc_clk_pin = 1'b0;
      rc_div = 1'b0;
      bus_req = '0;
      v0 = `BYTE_ZERO;
      v1 = `BYTE_ZERO;
      rows = '{'{4'h0, 8'h5A, 8'h00, 8'h5A}, '{4'h0, 8'hFF, 8'h00, 8'hFF}, '{4'h1, 8'h00, 8'hA5, 8'hA5},
               '{4'h1, 8'hFF, 8'h00, 8'h00}, '{4'h8, 8'h00, 8'h00, 8'hFF}, '{4'h9, 8'h00, 8'h00, 8'h80},
               '{4'hF, 8'hFF, 8'hFF, 8'h00}, '{4'h3, 8'hFF, 8'hFF, 8'h00}};
      do_reset();
      wr(`OFS_IRQ_MASK, 8'h01);
      foreach (rows[i]) begin
         v0 = rows[i].v0;
         v1 = rows[i].v1;
         convert({4'h2, rows[i].ch}, rows[i].res, 100);
         // two cycles of the status read precede the wait
         check("latency", 8'(n), 8'd42);
         $display("row %0d done", i);
      end
      rdc("irq status", `OFS_IRQ_STATUS, 8'h01);
      wr(`OFS_IRQ_MASK, 8'h00);
      check("irq masked", {7'h00, irq}, 8'h00);
      wr(`OFS_IRQ_MASK, 8'h01);
      check("irq unmasked", {7'h00, irq}, 8'h01);
      wr(`OFS_IRQ_STATUS, 8'h01);
      check("irq cleared", {7'h00, irq}, 8'h00);
      rdc("unmapped", 8'h20, 8'h00);
      wr(`OFS_RESULT, 8'h33);
      rdc("result read-only", `OFS_RESULT, 8'h00);
      $display("interrupt and access test done");
      wr(`OFS_STATUS_CONTROL, 8'hFF);
      rdc("status layout", `OFS_STATUS_CONTROL, 8'h6F);
      v0 = 8'h3C;
      convert(8'h60, 8'h3C, 400);
      wr(`OFS_STATUS_CONTROL, 8'h40);
      wr(`OFS_IRQ_STATUS, 8'h01);
      repeat (100) @(posedge clk);
      #1 check("rc only idle", {7'h00, irq}, 8'h00);
      $display("clock source test done");
      wr(`OFS_STATUS_CONTROL, 8'h60);
      repeat (20) @(posedge clk);
      do_reset();
      #1 check("power after reset", {6'h00, analog.rc_osc_enable, analog.converter_power_on}, 8'h00);
      rdc("status after reset", `OFS_STATUS_CONTROL, `STATUS_RESET);
      $display("reset test done");
      stop_test();
   end
endmodule : testbench

`default_nettype wire
